//--- gpc_regs.svh
// Register offsets, field positions, reset values and timing counts of the graphics power and clock control
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Configuration port byte offsets
`define GPC_PWR_OFFSET 8'hd4
`define GPC_CLK_OFFSET 8'hf0

// Power control and status fields
`define GPC_PWR_LSB 0
`define GPC_PWR_MSB 1
`define GPC_WAKE_EN_BIT 8
`define GPC_WAKE_STS_BIT 15
`define GPC_PWR_RESET 16'h0000

// Power level codes
`define GPC_LEVEL_D0 2'h0
`define GPC_LEVEL_D1 2'h1
`define GPC_LEVEL_D2 2'h2
`define GPC_LEVEL_D3 2'h3

// Clock control fields
`define GPC_DISP_GATE_BIT 9
`define GPC_REND_GATE_BIT 8
`define GPC_DISP_SEL_BIT 6
`define GPC_REND_SEL_LSB 4
`define GPC_REND_SEL_MSB 5
`define GPC_CLK_WMASK 16'h0370
`define GPC_CLK_RESET 16'h0000

// Render select codes
`define GPC_SEL_HIGH 2'h0
`define GPC_SEL_LOW 2'h1

// Core low clock as a divided enable of the 125 MHz device clock
`define GPC_CLK_PERIOD_NS 8
`define GPC_LOW_PERIOD_NS 32
`define GPC_LOW_DIV (`GPC_LOW_PERIOD_NS / `GPC_CLK_PERIOD_NS)

`endif

//--- gpc_pkg.sv
// Types shared by the graphics power and clock control modules
package gpc_pkg;

  // Clock trunk controls as held in the clock control register
  typedef struct packed {
    logic displayGate;
    logic renderGate;
    logic displaySel;
    logic [1:0] renderSel;
  } gpc_clk_ctrl_t;

endpackage

//--- gpc_clk_if.sv
// Trunk control bundle from the register block to the clock steering logic
`timescale 1ns/1ps
`default_nettype none

interface gpc_clk_if;
  gpc_pkg::gpc_clk_ctrl_t ctrl;

  modport source (output ctrl);
  modport sink (input ctrl);
endinterface

`default_nettype wire

//--- gpc_clock_steer.sv
// Clock steering: source selection and gating of the render and display trunk enables
`timescale 1ns/1ps
`default_nettype none
`include "gpc_regs.svh"

module gpc_clock_steer (
  input wire logic clock,
  input wire logic sys_rst,
  gpc_clk_if.sink trunk,
  output logic renderClkEn,
  output logic displayClkEn
);

  localparam int LowDiv = `GPC_LOW_DIV;

  logic [3:0] divCnt_r;
  logic [3:0] divCnt_nxt;
  logic renderClkEn_r;
  logic renderClkEn_nxt;
  logic displayClkEn_r;
  logic displayClkEn_nxt;
  logic lowTick;
  logic highTick;

  // Core high clock runs at device rate; low clock is a divided pulse
  always_comb begin
    highTick = 1'b1;
    lowTick = (divCnt_r == 4'(LowDiv - 1));
    divCnt_nxt = lowTick ? 4'h0 : divCnt_r + 4'h1;
  end

  // Reserved render codes give no clock rather than an undefined one
  always_comb begin
    renderClkEn_nxt = 1'b0;
    if (!trunk.ctrl.renderGate) begin
      unique case (trunk.ctrl.renderSel)
        `GPC_SEL_HIGH: renderClkEn_nxt = highTick;
        `GPC_SEL_LOW: renderClkEn_nxt = lowTick;
        default: renderClkEn_nxt = 1'b0;
      endcase
    end
    displayClkEn_nxt = 1'b0;
    if (!trunk.ctrl.displayGate) begin
      displayClkEn_nxt = trunk.ctrl.displaySel ? lowTick : highTick;
    end
  end

  // Registered enables keep the trunk outputs glitch free
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      divCnt_r <= 4'h0;
      renderClkEn_r <= 1'b0;
      displayClkEn_r <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      renderClkEn_r <= renderClkEn_nxt;
      displayClkEn_r <= displayClkEn_nxt;
    end
  end

  assign renderClkEn = renderClkEn_r;
  assign displayClkEn = displayClkEn_r;

  property p_render_gate;
    @(posedge clock) disable iff (sys_rst)
    trunk.ctrl.renderGate |=> !renderClkEn;
  endproperty
  a_render_gate: assert property (p_render_gate) else $error("render trunk ran while gated");

  property p_display_gate;
    @(posedge clock) disable iff (sys_rst)
    trunk.ctrl.displayGate[*2] |-> !displayClkEn;
  endproperty
  a_display_gate: assert property (p_display_gate) else $error("display trunk ran while gated");

  property p_display_high;
    @(posedge clock) disable iff (sys_rst)
    (!trunk.ctrl.displayGate && !trunk.ctrl.displaySel) |=> displayClkEn;
  endproperty
  a_display_high: assert property (p_display_high) else $error("display high clock missing");

  property p_render_low;
    @(posedge clock) disable iff (sys_rst)
    (!trunk.ctrl.renderGate && trunk.ctrl.renderSel == `GPC_SEL_LOW && !lowTick) |=> !renderClkEn;
  endproperty
  a_render_low: assert property (p_render_low) else $error("render low clock too fast");

endmodule

`default_nettype wire

//--- gpc_power_clock_ctrl.sv
// Graphics power level and core clock trunk control registers on the configuration port
`timescale 1ns/1ps
`default_nettype none
`include "gpc_regs.svh"

module gpc_power_clock_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [1:0] cfgByteEn,
  input wire logic [15:0] cfgWrData,
  output logic [15:0] cfgRdData,
  output logic cfgAck,
  output logic [1:0] powerLevel,
  output logic gfxResetPulse,
  output logic renderClkEn,
  output logic displayClkEn,
  output logic selectFault
);

  gpc_clk_if trunk ();

  logic [1:0] powerLevel_r;
  logic [1:0] powerLevel_nxt;
  gpc_pkg::gpc_clk_ctrl_t clkCtrl_r;
  gpc_pkg::gpc_clk_ctrl_t clkCtrl_nxt;
  logic gfxResetPulse_r;
  logic gfxResetPulse_nxt;
  logic [15:0] cfgRdData_r;
  logic [15:0] cfgRdData_nxt;
  logic cfgAck_r;
  logic cfgAck_nxt;
  logic selectFault_r;
  logic selectFault_nxt;
  logic hitPwrCtl;
  logic hitClkCtl;
  logic [15:0] pwrView;
  logic [15:0] clkView;
  logic [15:0] clkMerged;
  logic [1:0] newLevel;
  logic levelLegal;

  // Address decode; anything else reads zero and drops writes
  always_comb begin
    hitPwrCtl = (cfgAddr == `GPC_PWR_OFFSET);
    hitClkCtl = (cfgAddr == `GPC_CLK_OFFSET);
  end

  // Read images; only the implemented fields are ever nonzero
  always_comb begin
    pwrView = 16'h0000;
    pwrView[`GPC_PWR_MSB:`GPC_PWR_LSB] = powerLevel_r;
    pwrView[`GPC_WAKE_EN_BIT] = 1'b0;
    pwrView[`GPC_WAKE_STS_BIT] = 1'b0;
    clkView = 16'h0000;
    clkView[`GPC_DISP_GATE_BIT] = clkCtrl_r.displayGate;
    clkView[`GPC_REND_GATE_BIT] = clkCtrl_r.renderGate;
    clkView[`GPC_DISP_SEL_BIT] = clkCtrl_r.displaySel;
    clkView[`GPC_REND_SEL_MSB:`GPC_REND_SEL_LSB] = clkCtrl_r.renderSel;
  end

  // Byte lane merge of a clock control write; reserved bits masked off
  always_comb begin
    clkMerged = clkView;
    if (cfgByteEn[0]) begin
      clkMerged[7:0] = cfgWrData[7:0];
    end
    if (cfgByteEn[1]) begin
      clkMerged[15:8] = cfgWrData[15:8];
    end
    clkMerged = clkMerged & `GPC_CLK_WMASK;
  end

  // Power level update; D2 is not supported so its code is refused
  always_comb begin
    newLevel = cfgWrData[`GPC_PWR_MSB:`GPC_PWR_LSB];
    levelLegal = (newLevel == `GPC_LEVEL_D0) || (newLevel == `GPC_LEVEL_D1) || (newLevel == `GPC_LEVEL_D3);
    powerLevel_nxt = powerLevel_r;
    gfxResetPulse_nxt = 1'b0;
    if (cfgWrEn && hitPwrCtl && cfgByteEn[0]) begin
      if (levelLegal) begin
        powerLevel_nxt = newLevel;
        // Waking from D3 to D0 returns the clock control register to its reset value
        gfxResetPulse_nxt = (powerLevel_r == `GPC_LEVEL_D3) && (newLevel == `GPC_LEVEL_D0);
      end
    end
  end

  // Clock control update; the D3 wake reset takes precedence over a write
  always_comb begin
    clkCtrl_nxt = clkCtrl_r;
    if (gfxResetPulse_r) begin
      clkCtrl_nxt = '0;
    end else if (cfgWrEn && hitClkCtl) begin
      clkCtrl_nxt.displayGate = clkMerged[`GPC_DISP_GATE_BIT];
      clkCtrl_nxt.renderGate = clkMerged[`GPC_REND_GATE_BIT];
      clkCtrl_nxt.displaySel = clkMerged[`GPC_DISP_SEL_BIT];
      clkCtrl_nxt.renderSel = clkMerged[`GPC_REND_SEL_MSB:`GPC_REND_SEL_LSB];
    end
  end

  // Sticky flag for a selection change that broke the software sequence.
  // The hardware does not block it; the flag only helps bring-up debug.
  always_comb begin
    selectFault_nxt = selectFault_r;
    if (cfgWrEn && hitClkCtl && !gfxResetPulse_r) begin
      if (clkCtrl_nxt.renderSel != clkCtrl_r.renderSel && !clkCtrl_r.renderGate) begin
        selectFault_nxt = 1'b1;
      end
      if (clkCtrl_nxt.renderSel[1]) begin
        selectFault_nxt = 1'b1;
      end
      if (clkCtrl_nxt.displaySel != clkCtrl_r.displaySel &&
          !(clkCtrl_r.renderGate && clkCtrl_r.displayGate)) begin
        selectFault_nxt = 1'b1;
      end
      if (clkCtrl_nxt.displaySel && clkCtrl_nxt.renderSel != `GPC_SEL_LOW) begin
        selectFault_nxt = 1'b1;
      end
    end
  end

  // Read data and acknowledge; every access is answered next cycle
  always_comb begin
    cfgAck_nxt = cfgWrEn || cfgRdEn;
    cfgRdData_nxt = 16'h0000;
    if (cfgRdEn) begin
      if (hitPwrCtl) begin
        cfgRdData_nxt = pwrView;
      end else if (hitClkCtl) begin
        cfgRdData_nxt = clkView;
      end
    end
  end

  // State registers, all cleared by device reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      powerLevel_r <= `GPC_LEVEL_D0;
      clkCtrl_r <= '0;
      gfxResetPulse_r <= 1'b0;
      cfgRdData_r <= 16'h0000;
      cfgAck_r <= 1'b0;
      selectFault_r <= 1'b0;
    end else begin
      powerLevel_r <= powerLevel_nxt;
      clkCtrl_r <= clkCtrl_nxt;
      gfxResetPulse_r <= gfxResetPulse_nxt;
      cfgRdData_r <= cfgRdData_nxt;
      cfgAck_r <= cfgAck_nxt;
      selectFault_r <= selectFault_nxt;
    end
  end

  assign trunk.ctrl = clkCtrl_r;
  assign cfgRdData = cfgRdData_r;
  assign cfgAck = cfgAck_r;
  assign powerLevel = powerLevel_r;
  assign gfxResetPulse = gfxResetPulse_r;
  assign selectFault = selectFault_r;

  // Trunk enables from the selected core clock
  gpc_clock_steer steer (
    .clock(clock),
    .sys_rst(sys_rst),
    .trunk(trunk),
    .renderClkEn(renderClkEn),
    .displayClkEn(displayClkEn)
  );

  property p_level_write;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitPwrCtl && cfgByteEn[0] && cfgWrData[1:0] != `GPC_LEVEL_D2) |=> (powerLevel == $past(cfgWrData[1:0]));
  endproperty
  a_level_write: assert property (p_level_write) else $error("power level write not taken");

  property p_level_refuse;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitPwrCtl && cfgWrData[1:0] == `GPC_LEVEL_D2) |=> ($stable(powerLevel) && cfgAck);
  endproperty
  a_level_refuse: assert property (p_level_refuse) else $error("unsupported level not dropped");

  property p_wake_reset;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitPwrCtl && cfgByteEn[0] && powerLevel == `GPC_LEVEL_D3 && cfgWrData[1:0] == `GPC_LEVEL_D0)
      |=> gfxResetPulse ##1 (!gfxResetPulse && clkCtrl_r == '0);
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("D3 to D0 reset missing");

  property p_wake_status;
    @(posedge clock) disable iff (sys_rst)
    (cfgRdEn && hitPwrCtl) |=> (cfgAck && !cfgRdData[15] && cfgRdData[1:0] == powerLevel);
  endproperty
  a_wake_status: assert property (p_wake_status) else $error("wake status bit not zero");

  property p_wake_enable;
    @(posedge clock) disable iff (sys_rst)
    (cfgRdEn && hitPwrCtl) |=> (cfgAck && !cfgRdData[8]);
  endproperty
  a_wake_enable: assert property (p_wake_enable) else $error("wake enable bit not zero");

  property p_reserved;
    @(posedge clock) disable iff (sys_rst)
    (cfgRdEn && (hitClkCtl || hitPwrCtl)) |=> ((cfgRdData & 16'h7efc) == 16'h0000 || $past(hitClkCtl))
      && ((cfgRdData & 16'hfc8f) == 16'h0000 || $past(hitPwrCtl));
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_reset_clear;
    @(posedge clock) sys_rst |=> (powerLevel == `GPC_LEVEL_D0 && clkCtrl_r == '0 && !cfgAck);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

  property p_gate_write;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitClkCtl && cfgByteEn[1] && !gfxResetPulse) |=>
      (clkCtrl_r.renderGate == $past(cfgWrData[8]) && clkCtrl_r.displayGate == $past(cfgWrData[9]));
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate bits not written");

  property p_sel_write;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitClkCtl && cfgByteEn[0] && !gfxResetPulse) |=>
      (clkCtrl_r.renderSel == $past(cfgWrData[5:4]) && clkCtrl_r.displaySel == $past(cfgWrData[6]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select fields not written");

  property p_unmapped;
    @(posedge clock) disable iff (sys_rst)
    (cfgRdEn && !hitPwrCtl && !hitClkCtl) |=> (cfgAck && cfgRdData == 16'h0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Every request is answered exactly once, one cycle later
  property p_ack_pulse;
    @(posedge clock) disable iff (sys_rst)
    1'b1 |=> (cfgAck == $past(cfgWrEn || cfgRdEn));
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge not one cycle after request");

  // Read data is zero outside an answered read
  property p_idle_data;
    @(posedge clock) disable iff (sys_rst)
    !cfgRdEn |=> (cfgRdData == 16'h0000);
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data not zero when idle");

  // Level holds unless a low lane write reaches it
  property p_level_hold;
    @(posedge clock) disable iff (sys_rst)
    !(cfgWrEn && hitPwrCtl && cfgByteEn[0]) |=> $stable(powerLevel);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("power level changed without write");

  // Wake reset lasts a single cycle
  property p_pulse_one;
    @(posedge clock) disable iff (sys_rst)
    gfxResetPulse |=> !gfxResetPulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("wake reset pulse too long");

  // Clock control readback matches the held trunk controls
  property p_clk_readback;
    @(posedge clock) disable iff (sys_rst)
    (cfgRdEn && hitClkCtl) |=> (cfgRdData[9] == $past(clkCtrl_r.displayGate)
      && cfgRdData[8] == $past(clkCtrl_r.renderGate) && cfgRdData[6] == $past(clkCtrl_r.displaySel)
      && cfgRdData[5:4] == $past(clkCtrl_r.renderSel));
  endproperty
  a_clk_readback: assert property (p_clk_readback) else $error("clock control readback wrong");

  // Debug flag never clears outside reset
  property p_fault_sticky;
    @(posedge clock) disable iff (sys_rst)
    selectFault |=> selectFault;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("select fault flag cleared");

  // Render select changed while its trunk was running
  property p_fault_render;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitClkCtl && cfgByteEn[0] && !gfxResetPulse && !clkCtrl_r.renderGate
      && cfgWrData[5:4] != clkCtrl_r.renderSel) |=> selectFault;
  endproperty
  a_fault_render: assert property (p_fault_render) else $error("ungated render change not flagged");

  // Reserved render select code written
  property p_fault_reserved;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitClkCtl && cfgByteEn[0] && !gfxResetPulse && cfgWrData[5]) |=> selectFault;
  endproperty
  a_fault_reserved: assert property (p_fault_reserved) else $error("reserved render code not flagged");

  // Display low clock chosen while render is not on the low clock
  property p_fault_display;
    @(posedge clock) disable iff (sys_rst)
    (cfgWrEn && hitClkCtl && cfgByteEn[0] && !gfxResetPulse && cfgWrData[6]
      && cfgWrData[5:4] != `GPC_SEL_LOW) |=> selectFault;
  endproperty
  a_fault_display: assert property (p_fault_display) else $error("illegal display select not flagged");

endmodule

`default_nettype wire

//--- gpc_power_clock_ctrl_tb.sv
// Self-checking testbench of the graphics power level and clock trunk control registers
`timescale 1ns/1ps
`default_nettype none
`include "gpc_regs.svh"

// Compares a value with its expectation and counts the comparison
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin badCount++; \
  $display("ERROR %0t: mismatch got %h expected %h", $time, (got), (exp)); end end

module gpc_power_clock_ctrl_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cfgWrEn = 1'b0;
  logic cfgRdEn = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [1:0] cfgByteEn = 2'h0;
  logic [15:0] cfgWrData = 16'h0000;
  logic [15:0] cfgRdData;
  logic cfgAck;
  logic [1:0] powerLevel;
  logic gfxResetPulse;
  logic renderClkEn;
  logic displayClkEn;
  logic selectFault;
  int badCount = 0;
  int checked = 0;
  int seed = 32'h95da_ebf3;
  logic [16:0] expQ[$];
  logic [16:0] note;
  logic [15:0] d;
  logic [7:0] a;
  logic [1:0] lvl;
  logic [1:0] prev;

  gpc_power_clock_ctrl dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .cfgWrEn(cfgWrEn),
    .cfgRdEn(cfgRdEn),
    .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData),
    .cfgAck(cfgAck),
    .powerLevel(powerLevel),
    .gfxResetPulse(gfxResetPulse),
    .renderClkEn(renderClkEn),
    .displayClkEn(displayClkEn),
    .selectFault(selectFault)
  );

  // 125 MHz device clock
  always #4 clock = ~clock;

  // One request per call; the note is queued as the request is made
  task automatic acc(input logic wr, input logic [7:0] ad, input logic [1:0] be, input logic [15:0] dat,
                     input logic [15:0] exp);
    @(negedge clock);
    cfgWrEn = wr;
    cfgRdEn = ~wr;
    cfgAddr = ad;
    cfgByteEn = be;
    cfgWrData = dat;
    expQ.push_back({~wr, exp});
    @(negedge clock);
    cfgWrEn = 1'b0;
    cfgRdEn = 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [15:0] dat);
    acc(1'b1, ad, 2'h3, dat, 16'h0000);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] exp);
    acc(1'b0, ad, 2'h3, 16'h0000, exp);
  endtask

  // Counts enable pulses over a window once the register change has settled
  task automatic countEn(input int n, input int expR, input int expD);
    int r;
    int dc;
    r = 0;
    dc = 0;
    repeat (2) @(negedge clock);
    repeat (n) begin
      @(negedge clock);
      r += (renderClkEn === 1'b1) ? 1 : 0;
      dc += (displayClkEn === 1'b1) ? 1 : 0;
    end
    `CHECK(r, expR)
    `CHECK(dc, expD)
  endtask

  // Every acknowledge takes the oldest note; reads compare their data
  always @(negedge clock) begin
    if (cfgAck === 1'b1) begin
      if (expQ.size() == 0) begin
        badCount++;
        $display("ERROR %0t: acknowledge with no request pending", $time);
      end else begin
        note = expQ.pop_front();
        if (note[16]) `CHECK(cfgRdData, note[15:0])
      end
    end
  end

  task automatic finish_test;
    `CHECK(expQ.size(), 0)
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog well past the expected run of about 150 cycles
  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test;
  end

  initial begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    `CHECK(powerLevel, 2'h0)
    rd(`GPC_PWR_OFFSET, `GPC_PWR_RESET);
    rd(`GPC_CLK_OFFSET, `GPC_CLK_RESET);
    $display("test reset_values done");

    // Every level code with random upper bits, wake bits forced on; code 10 is dropped
    lvl = 2'h0;
    for (int c = 0; c < 4; c++) begin
      d = 16'($random(seed)) | 16'h8100;
      d[1:0] = c[1:0];
      prev = lvl;
      if (c != 2) lvl = c[1:0];
      wr(`GPC_PWR_OFFSET, d);
      `CHECK(gfxResetPulse, 1'b0)
      `CHECK(powerLevel, lvl)
      rd(`GPC_PWR_OFFSET, {14'h0, lvl});
    end
    // Wake from D3 to D0 returns the clock control register to its initial value
    wr(`GPC_CLK_OFFSET, 16'h0300);
    wr(`GPC_PWR_OFFSET, 16'h0000);
    `CHECK(gfxResetPulse, 1'b1)
    `CHECK(powerLevel, `GPC_LEVEL_D0)
    @(negedge clock);
    `CHECK(gfxResetPulse, 1'b0)
    rd(`GPC_CLK_OFFSET, 16'h0000);
    // Upper lane only cannot reach the level field
    acc(1'b1, `GPC_PWR_OFFSET, 2'h2, 16'h0003, 16'h0000);
    `CHECK(powerLevel, `GPC_LEVEL_D0)
    $display("test power_levels done");

    // Unmapped places drop writes and read zero
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      if (a == `GPC_PWR_OFFSET || a == `GPC_CLK_OFFSET) a = 8'h00;
      wr(a, 16'($random(seed)));
      rd(a, 16'h0000);
    end
    rd(`GPC_PWR_OFFSET, 16'h0000);
    $display("test unmapped done");

    // Trunks on the high clock, then the display gate alone, then both gates
    countEn(8, 8, 8);
    wr(`GPC_CLK_OFFSET, 16'h0200);
    countEn(8, 8, 0);
    d = 16'($random(seed));
    wr(`GPC_CLK_OFFSET, (d & ~`GPC_CLK_WMASK) | 16'h0300);
    rd(`GPC_CLK_OFFSET, 16'h0300);
    countEn(8, 0, 0);
    // Legal move to the low clock: gate, select render, select display, ungate
    wr(`GPC_CLK_OFFSET, 16'h0310);
    wr(`GPC_CLK_OFFSET, 16'h0350);
    wr(`GPC_CLK_OFFSET, 16'h0050);
    rd(`GPC_CLK_OFFSET, 16'h0050);
    countEn(8, 2, 2);
    // Legal move back to the high clock
    wr(`GPC_CLK_OFFSET, 16'h0350);
    wr(`GPC_CLK_OFFSET, 16'h0310);
    wr(`GPC_CLK_OFFSET, 16'h0300);
    wr(`GPC_CLK_OFFSET, 16'h0000);
    countEn(8, 8, 8);
    `CHECK(selectFault, 1'b0)
    $display("test clock_select done");

    // Reserved render code stops the render trunk and is flagged
    wr(`GPC_CLK_OFFSET, 16'h0100);
    wr(`GPC_CLK_OFFSET, 16'h0120);
    wr(`GPC_CLK_OFFSET, 16'h0020);
    countEn(8, 0, 8);
    `CHECK(selectFault, 1'b1)
    $display("test reserved_select done");

    // Reset in mid-run clears both registers
    wr(`GPC_PWR_OFFSET, 16'h0001);
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    `CHECK(powerLevel, 2'h0)
    `CHECK(selectFault, 1'b0)
    rd(`GPC_PWR_OFFSET, 16'h0000);
    rd(`GPC_CLK_OFFSET, 16'h0000);
    $display("test mid_reset done");

    // Display low clock picked ungated with render on high is taken but flagged
    wr(`GPC_CLK_OFFSET, 16'h0040);
    `CHECK(selectFault, 1'b1)
    rd(`GPC_CLK_OFFSET, 16'h0040);
    $display("test display_fault done");
    repeat (2) @(negedge clock);
    finish_test;
  end
endmodule

`default_nettype wire
